// ---- verilog/svcc_ctrl.sv ----
// serial vid code control: boot and fixed code latch, command apply, bus slave
// assumes an ahb-lite master on hclk and pins synchronised on entry

module svcc_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic link_clk,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic enable_in,
  input wire logic power_good_in,
  input wire logic serial_vid_clock,
  input wire logic serial_vid_data_in,
  output logic serial_vid_data_out,
  output logic serial_vid_data_oe,
  output logic [svcc_pkg::VID_W-1:0] core_reference_out,
  output logic [svcc_pkg::VID_W-1:0] aux_reference_out,
  output logic core_converter_on,
  output logic aux_converter_on,
  output logic core_soft_start,
  output logic aux_soft_start
);
  import svcc_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [4:0] meta_reg, sync_reg;
  logic en_s, pg_s, svc_s, svd_s, tgl_s;
  logic tgl_d_reg;
  svcc_mode_e mode_reg, mode_next;
  logic [1:0] boot_code_reg, fixed_code_reg;
  logic [1:0] boot_src, fixed_src;
  logic [VID_W-1:0] ref_reg [2];
  logic on_reg [2];
  logic ss_reg [2];
  logic listen_reg;
  logic ctrl_listen_reg;
  logic [15:0] cmd_cnt_reg;
  logic cmd_evt, cmd_apply;
  logic [1:0] cmd_sel;
  logic [VID_W-1:0] cmd_code;
  logic rx_ack_oe, rx_tgl;
  logic wr_pend_reg;
  logic [ADDR_W-1:0] addr_q_reg;
  logic rd_access, wr_access;
  logic [31:0] rd_mux;
  logic [15:0] tgt_core, tgt_aux;
  logic svd_out_reg;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 5'h00;
      sync_reg <= 5'h00;
    end else begin
      meta_reg <= {rx_tgl, serial_vid_data_in, serial_vid_clock, power_good_in, enable_in};
      sync_reg <= meta_reg;
    end
  end

  assign en_s = sync_reg[0];
  assign pg_s = sync_reg[1];
  assign svc_s = sync_reg[2];
  assign svd_s = sync_reg[3];
  assign tgl_s = sync_reg[4];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_d_reg <= 1'b0;
    end else begin
      tgl_d_reg <= tgl_s;
    end
  end

  assign cmd_evt = tgl_s ^ tgl_d_reg;
  assign cmd_apply = cmd_evt && (mode_reg == MODE_SVID) && (mode_next == MODE_SVID);

  // ****************************************
  // operating mode
  // ****************************************
  always_comb begin
    mode_next = mode_reg;
    if (!en_s) begin
      mode_next = MODE_OFF;
    end else begin
      unique case (mode_reg)
        MODE_OFF: mode_next = pg_s ? MODE_FIXED : MODE_BOOT;
        MODE_BOOT: mode_next = pg_s ? MODE_SVID : MODE_BOOT;
        MODE_SVID: mode_next = pg_s ? MODE_SVID : MODE_BOOT;
        MODE_FIXED: mode_next = MODE_FIXED;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= MODE_OFF;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ****************************************
  // code latch at the enable edge
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_code_reg <= 2'b00;
      fixed_code_reg <= 2'b00;
    end else if (mode_reg == MODE_OFF && en_s) begin
      if (pg_s) begin
        fixed_code_reg <= {svc_s, svd_s};
      end else begin
        boot_code_reg <= {svc_s, svd_s};
      end
    end
  end

  // the latch and the reference load share one edge
  assign boot_src = (mode_reg == MODE_OFF) ? {svc_s, svd_s} : boot_code_reg;
  assign fixed_src = (mode_reg == MODE_OFF) ? {svc_s, svd_s} : fixed_code_reg;

  // ****************************************
  // per output reference and converter state
  // ****************************************
  generate
    for (genvar i = 0; i < 2; i++) begin : g_out
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ref_reg[i] <= REF_RST;
          on_reg[i] <= 1'b0;
          ss_reg[i] <= 1'b0;
        end else begin
          ss_reg[i] <= 1'b0;
          unique case (mode_next)
            MODE_OFF: begin
              on_reg[i] <= 1'b0;
            end
            MODE_BOOT: begin
              ref_reg[i] <= svcc_boot_word(boot_src);
              on_reg[i] <= 1'b1;
              ss_reg[i] <= !on_reg[i];
            end
            MODE_FIXED: begin
              ref_reg[i] <= svcc_fixed_word(fixed_src);
              on_reg[i] <= 1'b1;
              ss_reg[i] <= !on_reg[i];
            end
            MODE_SVID: begin
              if (cmd_apply && cmd_sel[i]) begin
                if (svcc_is_off(cmd_code)) begin
                  on_reg[i] <= 1'b0;
                end else begin
                  ref_reg[i] <= cmd_code;
                  on_reg[i] <= 1'b1;
                  ss_reg[i] <= !on_reg[i];
                end
              end
            end
          endcase
        end
      end
    end
  endgenerate

  assign core_reference_out = ref_reg[0];
  assign aux_reference_out = ref_reg[1];
  assign core_converter_on = on_reg[0];
  assign aux_converter_on = on_reg[1];
  assign core_soft_start = ss_reg[0];
  assign aux_soft_start = ss_reg[1];
  assign tgt_core = svcc_target(ref_reg[0]);
  assign tgt_aux = svcc_target(ref_reg[1]);

  // ****************************************
  // link receiver
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      listen_reg <= 1'b0;
    end else begin
      listen_reg <= (mode_next == MODE_SVID) && ctrl_listen_reg;
    end
  end

  svcc_link_rx u_rx (
    .link_clk(link_clk),
    .hresetn(hresetn),
    .serial_vid_clock(serial_vid_clock),
    .serial_vid_data_in(serial_vid_data_in),
    .listen(listen_reg),
    .ack_oe(rx_ack_oe),
    .cmd_tgl(rx_tgl),
    .cmd_sel(cmd_sel),
    .cmd_code(cmd_code)
  );

  // open drain: only ever pulls low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svd_out_reg <= 1'b0;
    end else begin
      svd_out_reg <= 1'b0;
    end
  end

  assign serial_vid_data_out = svd_out_reg;
  assign serial_vid_data_oe = rx_ack_oe;

  // ****************************************
  // ahb-lite slave
  // ****************************************
  assign rd_access = hsel && hready && htrans[1] && !hwrite && (hsize == HSIZE_WORD);
  assign wr_access = hsel && hready && htrans[1] && hwrite && (hsize == HSIZE_WORD);

  always_comb begin
    unique case (haddr[ADDR_W-1:0])
      REG_CTRL: rd_mux = {31'h0000_0000, ctrl_listen_reg};
      REG_STATUS: rd_mux = {27'h000_0000, mode_reg, on_reg[1], on_reg[0], listen_reg};
      REG_CODES: rd_mux = {12'h000, fixed_code_reg, boot_code_reg, 1'b0, ref_reg[1], 1'b0, ref_reg[0]};
      REG_TARGET: rd_mux = {tgt_aux, tgt_core};
      REG_CMDCNT: rd_mux = {16'h0000, cmd_cnt_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_q_reg <= 5'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= wr_access;
      addr_q_reg <= haddr[ADDR_W-1:0];
      hrdata <= rd_access ? rd_mux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_listen_reg <= CTRL_LISTEN_RST;
    end else if (wr_pend_reg && addr_q_reg == REG_CTRL) begin
      ctrl_listen_reg <= hwdata[0];
    end
  end

  // an applied command in the clearing cycle still counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_cnt_reg <= 16'h0000;
    end else if (cmd_apply && cmd_sel != 2'b00) begin
      cmd_cnt_reg <= (wr_pend_reg && addr_q_reg == REG_CMDCNT) ? 16'h0001 : cmd_cnt_reg + 16'h0001;
    end else if (wr_pend_reg && addr_q_reg == REG_CMDCNT) begin
      cmd_cnt_reg <= 16'h0000;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_boot_enable;
    mode_reg == MODE_OFF && en_s && !pg_s;
  endsequence

  sequence s_svid_lost;
    mode_reg == MODE_SVID && en_s && !pg_s;
  endsequence

  sequence s_core_code;
    cmd_apply && cmd_sel[0] && !svcc_is_off(cmd_code);
  endsequence

  a_boot_latch_pins: assert property (s_boot_enable |=>
    mode_reg == MODE_BOOT && boot_code_reg == {$past(svc_s), $past(svd_s)})
    else $error("boot code not latched at enable");

  a_boot_ref_hold: assert property (mode_reg == MODE_BOOT |->
    ref_reg[0] == svcc_boot_word(boot_code_reg) && ref_reg[1] == ref_reg[0] && on_reg[0])
    else $error("references left the boot code");

  a_boot_return: assert property (s_svid_lost |=>
    mode_reg == MODE_BOOT ##0 ref_reg[1] == svcc_boot_word(boot_code_reg))
    else $error("power good loss did not restore boot code");

  a_listen_gate: assert property (listen_reg |-> mode_reg == MODE_SVID)
    else $error("receiver enabled outside serial mode");

  a_fixed_latch: assert property (mode_reg == MODE_OFF && en_s && pg_s |=>
    mode_reg == MODE_FIXED && ref_reg[0] == svcc_fixed_word({$past(svc_s), $past(svd_s)}))
    else $error("fixed code not latched at enable");

  a_fixed_hold: assert property (mode_reg == MODE_FIXED |->
    ref_reg[0] == svcc_fixed_word(fixed_code_reg) && ref_reg[1] == ref_reg[0] && !listen_reg)
    else $error("fixed mode references disturbed");

  a_cmd_update: assert property (s_core_code |=>
    ref_reg[0] == $past(cmd_code) && on_reg[0])
    else $error("core reference missed a command");

  a_off_shut: assert property (cmd_apply && cmd_sel[1] && svcc_is_off(cmd_code) |=>
    !on_reg[1] && $stable(ref_reg[1]))
    else $error("off code did not stop aux converter");

  a_soft_restart: assert property (s_core_code and !on_reg[0] |=>
    core_soft_start ##1 !core_soft_start)
    else $error("restart lacks a one cycle soft start pulse");

  a_target_floor: assert property (ref_reg[0] >= VID_FLOOR_CODE && !svcc_is_off(ref_reg[0]) |->
    tgt_core == VOLT_FLOOR_TMV)
    else $error("target below floor code is wrong");

endmodule : svcc_ctrl

// ---- verilog/svcc_pkg.sv ----
// constants, types and decoders shared by the serial vid code control block
// assumes a 125 MHz bus clock and a free running link sampling clock
package svcc_pkg;

  // ****************************************
  // widths and bus constants
  // ****************************************
  localparam int VID_W = 7;
  localparam int ADDR_W = 5;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] REG_CODES = 5'h08;
  localparam logic [ADDR_W-1:0] REG_TARGET = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_CMDCNT = 5'h10;
  localparam logic CTRL_LISTEN_RST = 1'b1;
  localparam logic [VID_W-1:0] REF_RST = 7'h7F;

  // ****************************************
  // voltage code constants, units of 0.1 mV
  // ****************************************
  localparam logic [VID_W-1:0] VID_FLOOR_CODE = 7'h54;
  localparam logic [VID_W-1:0] VID_OFF_CODE = 7'h7C;
  localparam logic [15:0] VOLT_TOP_TMV = 16'h3C8C;
  localparam logic [15:0] VOLT_STEP_TMV = 16'h007D;
  localparam logic [15:0] VOLT_FLOOR_TMV = 16'h1388;
  localparam logic [VID_W-1:0] VID_1V4 = 7'h0C;
  localparam logic [VID_W-1:0] VID_1V2 = 7'h1C;
  localparam logic [VID_W-1:0] VID_1V1 = 7'h24;
  localparam logic [VID_W-1:0] VID_1V0 = 7'h2C;
  localparam logic [VID_W-1:0] VID_0V9 = 7'h34;
  localparam logic [VID_W-1:0] VID_0V8 = 7'h3C;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_BOOT = 2'b01,
    MODE_SVID = 2'b10,
    MODE_FIXED = 2'b11
  } svcc_mode_e;

  // ****************************************
  // decoders
  // ****************************************
  function automatic logic [VID_W-1:0] svcc_boot_word(input logic [1:0] pins);
    unique case (pins)
      2'b00: svcc_boot_word = VID_1V1;
      2'b01: svcc_boot_word = VID_1V0;
      2'b10: svcc_boot_word = VID_0V9;
      2'b11: svcc_boot_word = VID_0V8;
    endcase
  endfunction : svcc_boot_word

  function automatic logic [VID_W-1:0] svcc_fixed_word(input logic [1:0] pins);
    unique case (pins)
      2'b00: svcc_fixed_word = VID_1V4;
      2'b01: svcc_fixed_word = VID_1V2;
      2'b10: svcc_fixed_word = VID_1V0;
      2'b11: svcc_fixed_word = VID_0V8;
    endcase
  endfunction : svcc_fixed_word

  function automatic logic svcc_is_off(input logic [VID_W-1:0] code);
    svcc_is_off = (code >= VID_OFF_CODE);
  endfunction : svcc_is_off

  // target level, zero when the code means off
  function automatic logic [15:0] svcc_target(input logic [VID_W-1:0] code);
    if (svcc_is_off(code)) begin
      svcc_target = 16'h0000;
    end else if (code >= VID_FLOOR_CODE) begin
      svcc_target = VOLT_FLOOR_TMV;
    end else begin
      svcc_target = VOLT_TOP_TMV - VOLT_STEP_TMV * {9'h000, code};
    end
  endfunction : svcc_target

endpackage : svcc_pkg

// ---- verilog/svcc_link_rx.sv ----
// serial vid receiver: start detect, address and data bytes, acknowledge
// assumes link_clk oversamples the bus pins; runs entirely on link_clk
module svcc_link_rx (
  input wire logic link_clk,
  input wire logic hresetn,
  input wire logic serial_vid_clock,
  input wire logic serial_vid_data_in,
  input wire logic listen,
  output logic ack_oe,
  output logic cmd_tgl,
  output logic [1:0] cmd_sel,
  output logic [svcc_pkg::VID_W-1:0] cmd_code
);
  import svcc_pkg::*;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_ADDR = 3'b001,
    RX_ACK_ADDR = 3'b010,
    RX_DATA = 3'b011,
    RX_ACK_DATA = 3'b100
  } svcc_rx_e;

  logic rst_meta_reg, rst_sync_reg;
  logic [2:0] meta_reg, sync_reg;
  logic svc_d_reg, svd_d_reg;
  svcc_rx_e state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic rise, fall, start, stop;

  function automatic logic addr_ok(input logic [7:0] b);
    addr_ok = (b[7:5] == 3'b110) && !b[0] && (b[2:1] != 2'b00);
  endfunction : addr_ok

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  always_ff @(posedge link_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      svc_d_reg <= 1'b1;
      svd_d_reg <= 1'b1;
    end else begin
      meta_reg <= {listen, serial_vid_data_in, serial_vid_clock};
      sync_reg <= meta_reg;
      svc_d_reg <= sync_reg[0];
      svd_d_reg <= sync_reg[1];
    end
  end

  assign rise = sync_reg[0] && !svc_d_reg;
  assign fall = !sync_reg[0] && svc_d_reg;
  assign start = sync_reg[0] && svc_d_reg && svd_d_reg && !sync_reg[1];
  assign stop = sync_reg[0] && svc_d_reg && !svd_d_reg && sync_reg[1];

  // ****************************************
  // byte framing
  // ****************************************
  always_ff @(posedge link_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= RX_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (!sync_reg[2]) begin
      state_reg <= RX_IDLE;
    end else if (start) begin
      state_reg <= RX_ADDR;
      cnt_reg <= 4'h0;
    end else if (stop) begin
      state_reg <= RX_IDLE;
    end else begin
      unique case (state_reg)
        RX_IDLE: begin
        end
        RX_ADDR, RX_DATA: begin
          if (rise && cnt_reg != 4'h8) begin
            shift_reg <= {shift_reg[6:0], sync_reg[1]};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (fall && cnt_reg == 4'h8) begin
            if (state_reg == RX_DATA) begin
              state_reg <= RX_ACK_DATA;
            end else if (addr_ok(shift_reg)) begin
              state_reg <= RX_ACK_ADDR;
            end else begin
              state_reg <= RX_IDLE;
            end
          end
        end
        RX_ACK_ADDR: begin
          if (fall) begin
            state_reg <= RX_DATA;
            cnt_reg <= 4'h0;
          end
        end
        RX_ACK_DATA: begin
          if (fall) begin
            state_reg <= RX_IDLE;
          end
        end
        default: begin
          state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // acknowledge drive and command hand-off
  // ****************************************
  always_ff @(posedge link_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ack_oe <= 1'b0;
    end else begin
      ack_oe <= (state_reg == RX_ACK_ADDR) || (state_reg == RX_ACK_DATA);
    end
  end

  // data words load at their byte ends, before the toggle, and hold until the next frame, so the bus side samples them settled
  always_ff @(posedge link_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cmd_tgl <= 1'b0;
      cmd_sel <= 2'b00;
      cmd_code <= REF_RST;
    end else begin
      if (state_reg == RX_ADDR && fall && cnt_reg == 4'h8) begin
        cmd_sel <= {shift_reg[1], shift_reg[2]};
      end
      if (state_reg == RX_DATA && fall && cnt_reg == 4'h8) begin
        cmd_code <= shift_reg[VID_W-1:0];
      end
      if (state_reg == RX_ACK_DATA && fall && sync_reg[2] && !start && !stop) begin
        cmd_tgl <= !cmd_tgl;
      end
    end
  end

  a_ack_addr_match: assert property (@(posedge link_clk) disable iff (!rst_sync_reg)
    state_reg == RX_ACK_ADDR |-> addr_ok(shift_reg))
    else $error("address acknowledged without a match");

endmodule : svcc_link_rx

// ---- sim/svcc_host_model.sv ----
// host processor model driving the serial vid clock and data lines
// assumes the bench resolves the data wire with a pull-up and the device ack
module svcc_host_model (
  input wire logic link_clk,
  input wire logic data_wire,
  output logic clk_pin,
  output logic data_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // pin driving
  // ****************************************
  initial begin
    clk_pin = 1'h1;
    data_drv = 1'h1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge link_clk);
  endtask : wt
  // static levels for the code latched at enable
  task automatic set_pins(input logic [1:0] code);
    wt(1);
    clk_pin <= code[1];
    data_drv <= code[0];
  endtask : set_pins
  // between start and stop, data only moves while the clock is low, so no false start or stop
  task automatic send(input logic [7:0] addr, input logic [7:0] dat, output logic [1:0] acks);
    logic [17:0] bits;
    bits = {addr, 1'h1, dat, 1'h1};
    acks = 2'h0;
    wt(1);
    clk_pin <= 1'h1;
    data_drv <= 1'h1;
    wt(7);
    data_drv <= 1'h0;
    wt(7);
    clk_pin <= 1'h0;
    for (int i = 17; i >= 0; i--) begin
      wt(3);
      data_drv <= bits[i];
      wt(4);
      clk_pin <= 1'h1;
      wt(3);
      if (i == 9 || i == 0) acks = {acks[0], ~data_wire};
      wt(4);
      clk_pin <= 1'h0;
    end
    wt(3);
    data_drv <= 1'h0;
    wt(4);
    clk_pin <= 1'h1;
    wt(7);
    data_drv <= 1'h1;
    wt(7);
  endtask : send
endmodule : svcc_host_model

// ---- sim/svcc_ctrl_tb_top.sv ----
// self checking bench for the serial vid code control block
// assumes svcc_host_model on the serial pins and a pull-up on the data wire
module svcc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import svcc_pkg::*;
  // ****************************************
  // clocks, pins and the design
  // ****************************************
  logic hclk = 1'h0;
  logic link_clk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic enable_in = 1'h0;
  logic power_good_in = 1'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic sv_clk;
  logic data_drv;
  logic data_out;
  logic data_oe;
  logic [VID_W-1:0] core_ref;
  logic [VID_W-1:0] aux_ref;
  logic core_on;
  logic aux_on;
  logic core_ss;
  logic aux_ss;
  logic ss_seen = 1'h0;
  logic [1:0] acks;
  logic [31:0] rd;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  wire data_wire = data_oe ? data_out : data_drv;
  always #4 hclk = ~hclk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  svcc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .link_clk(link_clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .enable_in(enable_in),
    .power_good_in(power_good_in), .serial_vid_clock(sv_clk), .serial_vid_data_in(data_wire),
    .serial_vid_data_out(data_out), .serial_vid_data_oe(data_oe), .core_reference_out(core_ref),
    .aux_reference_out(aux_ref), .core_converter_on(core_on), .aux_converter_on(aux_on),
    .core_soft_start(core_ss), .aux_soft_start(aux_ss));
  svcc_host_model host (.link_clk(link_clk), .data_wire(data_wire), .clk_pin(sv_clk), .data_drv(data_drv));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  always @(posedge hclk) begin
    cycles++;
    if (core_ss === 1'h1 && aux_ss === 1'h1) ss_seen <= 1'h1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one single word transfer; waits on hready rather than assuming zero waits
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic pins(input logic en, input logic pg);
    enable_in <= en;
    power_good_in <= pg;
    repeat (6) @(posedge hclk);
  endtask : pins
  task automatic frame(input logic [7:0] a, input logic [7:0] d);
    host.send(a, d, acks);
    repeat (25) @(posedge hclk);
  endtask : frame
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("core ref", 32'h0000_007F, core_ref);
    chk("core on", 32'h0000_0000, core_on);
    bus(1'h0, REG_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0001, rd);
    chk("resp", 32'h0000_0000, hresp);
    bus(1'h0, 32'h0000_001C, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    $display("test reset done");
  endtask : t_reset
  // tbl holds the expected word for pin codes 3..0, msb first
  task automatic t_latch(input logic pg, input logic [27:0] tbl);
    for (int i = 0; i < 4; i++) begin
      pins(1'h0, pg);
      host.set_pins(i[1:0]);
      @(posedge hclk);
      pins(1'h1, pg);
      chk("core ref", {25'h0, tbl[7*i +: 7]}, core_ref);
      chk("aux ref", {25'h0, tbl[7*i +: 7]}, aux_ref);
    end
    $display("test latch done");
  endtask : t_latch
  task automatic t_fixed();
    frame(8'hC6, 8'h10);
    chk("acks", 32'h0000_0000, acks);
    chk("core ref", 32'h0000_003C, core_ref);
    $display("test fixed done");
  endtask : t_fixed
  task automatic t_serial();
    frame(8'hC4, 8'h05);
    chk("acks", 32'h0000_0000, acks);
    chk("core ref", 32'h0000_003C, core_ref);
    pins(1'h1, 1'h1);
    frame(8'hDC, 8'h8A);
    chk("acks", 32'h0000_0003, acks);
    chk("core ref", 32'h0000_000A, core_ref);
    chk("aux ref", 32'h0000_003C, aux_ref);
    bus(1'h0, REG_TARGET, 32'h0000_0000);
    chk("target", 32'h1F40_37AA, rd);
    frame(8'hC2, 8'h60);
    chk("aux ref", 32'h0000_0060, aux_ref);
    bus(1'h0, REG_TARGET, 32'h0000_0000);
    chk("target", 32'h1388_37AA, rd);
    frame(8'hCE, 8'h7D);
    chk("acks", 32'h0000_0003, acks);
    chk("on", 32'h0000_0000, {core_on, aux_on});
    chk("core ref", 32'h0000_000A, core_ref);
    ss_seen <= 1'h0;
    frame(8'hC6, 8'h54);
    chk("refs", 32'h0000_5454, {core_ref, 1'h0, aux_ref});
    chk("restart", 32'h0000_0007, {core_on, aux_on, ss_seen});
    frame(8'hC0, 8'h10);
    chk("acks", 32'h0000_0000, acks);
    chk("core ref", 32'h0000_0054, core_ref);
    bus(1'h0, REG_CMDCNT, 32'h0000_0000);
    chk("cmd count", 32'h0000_0004, rd);
    bus(1'h1, REG_CMDCNT, 32'h0000_0000);
    bus(1'h0, REG_CMDCNT, 32'h0000_0000);
    chk("cmd count", 32'h0000_0000, rd);
    bus(1'h1, REG_CTRL, 32'h0000_0000);
    frame(8'hC4, 8'h10);
    chk("acks", 32'h0000_0000, acks);
    bus(1'h1, REG_CTRL, 32'h0000_0001);
    pins(1'h1, 1'h0);
    chk("refs", 32'h0000_3C3C, {core_ref, 1'h0, aux_ref});
    bus(1'h0, REG_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_000E, rd);
    bus(1'h0, REG_CODES, 32'h0000_0000);
    chk("codes", 32'h000F_3C3C, rd);
    $display("test serial done");
  endtask : t_serial
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (3) @(posedge hclk);
    t_reset();
    t_latch(1'h1, {7'h3C, 7'h2C, 7'h1C, 7'h0C});
    t_fixed();
    t_latch(1'h0, {7'h3C, 7'h34, 7'h2C, 7'h24});
    t_serial();
    wrap_up();
  end
endmodule : svcc_ctrl_tb_top
